// ---- verilog/redist_pend_clear_group_ctrl.v ----
// Purpose: pending clear, group status and group modifier of one redistributor
// Assumes: register port on clk; interrupt lines asynchronous
// Notes:   one instance per redistributor holds its own copy
//
// Contract
// - reading a clear-pending bit returns 1 if pending or active-and-pending.
// - writing 1 clears pending: pending to inactive, active-and-pending to active.
// - writing 0 does nothing; writing 1 to a non-pending interrupt does nothing.
// - clear does not remove level pending driven by the asserted input.
// - clear-pending bit is RAZ/WI when affinity routing is off for its state.
// - bits 31:16 are private peripheral, bits 15:0 software-raised interrupts.
// - security enabled: secure bits of clear-pending are RAZ/WI to non-secure.
// - security enabled: group status and modifier are RAZ/WI to non-secure.
// - group status bits of unimplemented interrupts are RAZ/WI.
// - security disabled: status 0 is group 0, status 1 is group 1.
// - security enabled: status 0 secure, 1 non-secure group 1, per modifier.
// - modifier,status: 00 G0 secure, 01 G1 non-secure, 10 G1 secure, 11 as 01.
// - modifier is RAZ/WI if secure affinity off or security disabled.
// - modifier bit is zero when affinity is off for the interrupt's state.
// - group change while pending: old or new setting, never lost or doubled.
// - each redistributor keeps its own copy of these registers.
// - without affinity, first eight elements reach group status via an alias.
// - secure group one selectable only with system register access enabled.
// - read-write fields come out of reset with unspecified values.
// - trigger bit 0 is level-sensitive, 1 is edge-triggered.
`default_nettype none
`include "redist_pend_map.vh"
module redist_pend_clear_group_ctrl (
    input  wire                  clk,
    input  wire                  rst_n,
    input  wire                  ce,
    input  wire                  reg_wr_en,
    input  wire                  reg_rd_en,
    input  wire [`ADDR_W-1:0]    reg_addr,
    input  wire [31:0]           reg_wdata,
    input  wire                  reg_nonsecure,
    input  wire                  reg_mod_sel,
    output reg  [31:0]           reg_rdata,
    output reg                   reg_rd_valid,
    input  wire                  alias_wr_en,
    input  wire                  alias_rd_en,
    input  wire [31:0]           alias_wdata,
    input  wire                  processing_element_first_eight,
    output reg  [31:0]           alias_rdata,
    input  wire                  security_disable_flag,
    input  wire                  secure_affinity_route_enable,
    input  wire                  nonsecure_affinity_route_enable,
    input  wire                  sysreg_access_enable,
    input  wire [`NUM_PRIV-1:0]  per_core_private_irq,
    input  wire [`NUM_SOFT-1:0]  software_raised_irq,
    input  wire [`NUM_IRQ-1:0]   shared_set_pending_reg,
    output reg  [`NUM_IRQ-1:0]   pending_out,
    output reg  [2*`NUM_IRQ-1:0] group_code_out
);
    // read-write fields, deliberately not reset
    reg  [31:0] group_reg;
    reg  [31:0] group_next;
    reg  [31:0] mod_reg;
    reg  [31:0] mod_next;
    reg  [31:0] cfg_reg;
    reg  [31:0] cfg_next;

    // input synchroniser and edge memory for the private lines
    reg  [`NUM_PRIV-1:0] line_meta_reg;
    reg  [`NUM_PRIV-1:0] line_sync_reg;
    reg  [`NUM_PRIV-1:0] line_prev_reg;

    reg  [31:0] rdata_next;

    wire        sec_off;
    wire        ns_blocked;
    wire [31:0] impl_mask;
    wire        wr_group;
    wire        wr_mod;
    wire        wr_clr;
    wire        wr_cfg;
    wire        mod_open;
    wire [31:0] irq_secure;
    wire [31:0] are_ok;
    wire [31:0] clr_ok;
    wire [31:0] group_ok;
    wire [31:0] mod_ok;
    wire [31:0] mod_live;
    wire [31:0] cfg_ok;
    wire [31:0] alias_ok;
    wire [31:0] edge_mode;
    wire [31:0] line_level;
    wire [31:0] raise;
    wire [31:0] clear_req;
    wire [31:0] pending;
    wire [63:0] group_code;

    assign sec_off    = security_disable_flag;
    assign ns_blocked = reg_nonsecure & ~sec_off;
    assign impl_mask  = `IMPL_MASK;

    // modifier bank shares its offset with group status; a select picks it
    assign wr_group = reg_wr_en & ~reg_mod_sel & (reg_addr == `OFS_GROUP);
    assign wr_mod   = reg_wr_en &  reg_mod_sel & (reg_addr == `OFS_GROUP);
    assign wr_clr   = reg_wr_en & (reg_addr == `OFS_CLR_PEND);
    assign wr_cfg   = reg_wr_en & (reg_addr == `OFS_CFG_HI);

    // whole modifier bank only lives with two states and secure routing
    assign mod_open = secure_affinity_route_enable & ~sec_off;

    genvar i;
    generate
        for (i = 0; i < `NUM_IRQ; i = i + 1) begin : g_irq
            // with security on, status 0 means the interrupt is secure
            assign irq_secure[i] = ~sec_off & ~group_reg[i];

            // routing flag of the interrupt's own security state
            assign are_ok[i] = (sec_off | irq_secure[i]) ? secure_affinity_route_enable
                                                         : nonsecure_affinity_route_enable;

            assign clr_ok[i] = are_ok[i]
                             & ~(ns_blocked & irq_secure[i])
                             & impl_mask[i];

            assign group_ok[i] = ~ns_blocked & impl_mask[i];

            assign mod_ok[i] = mod_open & are_ok[i] & ~ns_blocked;

            // secure group one needs system register access
            assign mod_live[i] = mod_open & are_ok[i] & sysreg_access_enable;

            // legacy alias only for the first eight elements, affinity off
            assign alias_ok[i] = processing_element_first_eight & ~are_ok[i]
                               & impl_mask[i];

            assign clear_req[i] = wr_clr & reg_wdata[i] & clr_ok[i];

            group_decode u_decode (
                .status_bit (group_reg[i]),
                .mod_bit    (mod_reg[i] & mod_live[i]),
                .code       (group_code[2*i+1:2*i])
            );

            pend_cell u_cell (
                .clk        (clk),
                .rst_n      (rst_n),
                .ce         (ce),
                .edge_mode  (edge_mode[i]),
                .line_level (line_level[i]),
                .raise      (raise[i]),
                .clear_req  (clear_req[i]),
                .pending    (pending[i])
            );
        end

        // software-raised interrupts are always edge, no input line
        for (i = 0; i < `NUM_SOFT; i = i + 1) begin : g_soft
            assign edge_mode[i]  = 1'b1;
            assign line_level[i] = 1'b0;
            assign raise[i]      = software_raised_irq[i] | shared_set_pending_reg[i];
            assign cfg_ok[2*i]   = 1'b0;
            assign cfg_ok[2*i+1] = are_ok[`PRIV_BASE+i]
                                 & ~(ns_blocked & irq_secure[`PRIV_BASE+i]);
        end

        for (i = 0; i < `NUM_PRIV; i = i + 1) begin : g_priv
            assign edge_mode[`PRIV_BASE+i]  = cfg_reg[2*i+1];
            assign line_level[`PRIV_BASE+i] = line_sync_reg[i];
            // edge mode latches a rising edge; level mode only a software set
            assign raise[`PRIV_BASE+i] = (cfg_reg[2*i+1] & line_sync_reg[i] & ~line_prev_reg[i])
                                       | shared_set_pending_reg[`PRIV_BASE+i];
        end
    endgenerate

    // group status: register port and legacy alias
    always @* begin
        group_next = group_reg;
        if (wr_group) begin
            group_next = (group_reg & ~group_ok) | (reg_wdata & group_ok);
        end
        if (alias_wr_en) begin
            group_next = (group_next & ~alias_ok) | (alias_wdata & alias_ok);
        end
    end

    always @* begin
        mod_next = mod_reg;
        if (wr_mod) begin
            mod_next = (mod_reg & ~mod_ok) | (reg_wdata & mod_ok);
        end
    end

    // only odd trigger bits hold state; even ones read zero
    always @* begin
        cfg_next = cfg_reg;
        if (wr_cfg) begin
            cfg_next = (cfg_reg & ~(cfg_ok & `CFG_ODD_MASK))
                     | (reg_wdata & cfg_ok & `CFG_ODD_MASK);
        end
    end

    // fields carry no reset; software must program them before use
    always @(posedge clk) begin
        if (ce) begin
            group_reg <= group_next;
            mod_reg   <= mod_next;
            cfg_reg   <= cfg_next;
        end
    end

    // first stage read by the second stage only
    always @(posedge clk) begin
        if (!rst_n) begin
            line_meta_reg <= {`NUM_PRIV{1'b0}};
            line_sync_reg <= {`NUM_PRIV{1'b0}};
            line_prev_reg <= {`NUM_PRIV{1'b0}};
        end else if (ce) begin
            line_meta_reg <= per_core_private_irq;
            line_sync_reg <= line_meta_reg;
            line_prev_reg <= line_sync_reg;
        end
    end

    // read data; unmapped offsets read zero
    always @* begin
        rdata_next = `ZERO32;
        case (reg_addr)
            `OFS_GROUP: begin
                if (reg_mod_sel) begin
                    rdata_next = mod_reg & mod_ok;
                end else begin
                    rdata_next = group_reg & group_ok;
                end
            end
            `OFS_CLR_PEND: begin
                rdata_next = pending & clr_ok;
            end
            `OFS_CFG_HI: begin
                rdata_next = cfg_reg & cfg_ok & `CFG_ODD_MASK;
            end
            default: begin
                rdata_next = `ZERO32;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata    <= `ZERO32;
            reg_rd_valid <= 1'b0;
            alias_rdata  <= `ZERO32;
        end else if (ce) begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rdata_next;
            end
            if (alias_rd_en) begin
                alias_rdata <= group_reg & alias_ok;
            end
        end
    end

    // codes follow the fields one cycle later; pending state is untouched
    // by group writes, so nothing is dropped or raised twice
    always @(posedge clk) begin
        if (!rst_n) begin
            pending_out    <= `ZERO32;
            group_code_out <= {`ZERO32, `ZERO32};
        end else if (ce) begin
            pending_out    <= pending;
            group_code_out <= group_code;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/redist_pend_map.vh ----
// Purpose: offsets, widths and encodings of the private interrupt frame
// Assumes: included by bare name, definitions only
// Notes:   offsets are byte addresses within the private frame
`ifndef REDIST_PEND_MAP_VH
`define REDIST_PEND_MAP_VH

`define ADDR_W        12
`define NUM_IRQ       32
`define NUM_SOFT      16
`define NUM_PRIV      16
`define PRIV_BASE     16
`define OFS_GROUP     12'h000
`define OFS_CLR_PEND  12'h280
`define OFS_CFG_HI    12'hc04
`define ZERO32        32'h0000_0000
`define IMPL_MASK     32'hffff_ffff
`define CFG_ODD_MASK  32'haaaa_aaaa
`define CODE_SEC_GRP0 2'h0
`define CODE_NS_GRP1  2'h1
`define CODE_SEC_GRP1 2'h2
`define CODE_RSVD     2'h3

`endif

// ---- verilog/pend_cell.v ----
// Purpose: pending state of one private interrupt
// Assumes: raise and clear_req are one-cycle pulses on clk
// Notes:   level pending from the line cannot be cleared by software
`default_nettype none
module pend_cell (
    input  wire clk,
    input  wire rst_n,
    input  wire ce,
    input  wire edge_mode,
    input  wire line_level,
    input  wire raise,
    input  wire clear_req,
    output wire pending
);
    reg latch_reg;
    reg latch_next;

    always @* begin
        latch_next = latch_reg;
        if (clear_req) begin
            latch_next = 1'b0;
        end
        if (raise) begin
            latch_next = 1'b1; // set wins over clear
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            latch_reg <= 1'b0;
        end else if (ce) begin
            latch_reg <= latch_next;
        end
    end

    // line term stays while asserted, whatever software writes
    assign pending = latch_reg | (~edge_mode & line_level);
endmodule
`default_nettype wire

// ---- verilog/group_decode.v ----
// Purpose: two-bit group code of one interrupt
// Assumes: mod_bit already forced low where it is not meaningful
// Notes:   the reserved code folds onto non-secure group one
`default_nettype none
`include "redist_pend_map.vh"
module group_decode (
    input  wire       status_bit,
    input  wire       mod_bit,
    output reg  [1:0] code
);
    always @* begin
        case ({mod_bit, status_bit})
            `CODE_SEC_GRP0: code = `CODE_SEC_GRP0;
            `CODE_NS_GRP1:  code = `CODE_NS_GRP1;
            `CODE_SEC_GRP1: code = `CODE_SEC_GRP1;
            `CODE_RSVD:     code = `CODE_NS_GRP1;
            default:        code = `CODE_SEC_GRP0;
        endcase
    end
endmodule
`default_nettype wire

// ---- verification/irq_lines.sv ----
// Purpose: private interrupt lines as the far side drives them
// Assumes: lines are asynchronous to the block clock
// Notes:   off-grid delay makes the block's synchroniser do real work
`default_nettype none
module irq_lines (
    input  wire logic [15:0] line_req,
    output var  logic [15:0] per_core_private_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // level held as long as the source wants service
    always @(line_req) per_core_private_irq <= #7 line_req;
endmodule
`default_nettype wire

// ---- verification/redist_pend_chk.sv ----
// Purpose: port checks of pending clear and group logic
// Assumes: one clock domain, bound to the top module
// Notes:   codes may lag a config change by up to two edges
`default_nettype none
`include "redist_pend_map.vh"
module redist_pend_chk (
    input wire logic                   clk, rst_n, ce, reg_rd_en, reg_mod_sel,
    input wire logic                   reg_nonsecure, reg_rd_valid,
    input wire logic [`ADDR_W-1:0]     reg_addr,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   security_disable_flag, sysreg_access_enable,
    input wire logic                   secure_affinity_route_enable,
    input wire logic [`NUM_IRQ-1:0]    shared_set_pending_reg, pending_out,
    input wire logic [2*`NUM_IRQ-1:0]  group_code_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hi_any, rsvd_any, sec_g1_any;
    wire  rd_go = ce && reg_rd_en;
    always_comb begin
        hi_any = 1'b0;
        rsvd_any = 1'b0;
        sec_g1_any = 1'b0;
        for (int i = 0; i < `NUM_IRQ; i++) begin
            hi_any |= group_code_out[2*i+1];
            rsvd_any |= &group_code_out[2*i+:2];
            sec_g1_any |= group_code_out[2*i+:2] == `CODE_SEC_GRP1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence rd_grp_s;
        rd_go && reg_addr == `OFS_GROUP;
    endsequence
    rd_valid_a: assert property (rd_go |=> reg_rd_valid) else $error("no read valid");
    rd_once_a: assert property (ce && !reg_rd_en |=> !reg_rd_valid) else $error("stray valid");
    rd_hold_a: assert property (!reg_rd_valid |-> $stable(reg_rdata)) else $error("rdata moved");
    set_pend_a: assert property (ce && |shared_set_pending_reg |-> ##2
        (pending_out & $past(shared_set_pending_reg, 2)) == $past(shared_set_pending_reg, 2))
        else $error("set lost");
    ns_grp_raz_a: assert property (rd_grp_s ##0 (reg_nonsecure && !security_disable_flag)
        |=> reg_rdata == `ZERO32) else $error("nonsecure group read");
    mod_raz_a: assert property (rd_grp_s ##0 (reg_mod_sel &&
        (security_disable_flag || !secure_affinity_route_enable)) |=> reg_rdata == `ZERO32)
        else $error("modifier not zero");
    unmapped_a: assert property (rd_go && reg_addr != `OFS_GROUP && reg_addr != `OFS_CLR_PEND
        && reg_addr != `OFS_CFG_HI |=> reg_rdata == `ZERO32) else $error("unmapped data");
    cfg_even_a: assert property (rd_go && reg_addr == `OFS_CFG_HI
        |=> (reg_rdata & ~`CFG_ODD_MASK) == `ZERO32) else $error("even cfg bit");
    rsvd_code_a: assert property (!rsvd_any) else $error("reserved code out");
    two_group_a: assert property (security_disable_flag && $past(security_disable_flag)
        && $past(security_disable_flag, 2) |-> !hi_any) else $error("modifier used");
    no_g1s_a: assert property (!sysreg_access_enable && !$past(sysreg_access_enable)
        && !$past(sysreg_access_enable, 2) |-> !sec_g1_any) else $error("secure group one");
endmodule
bind redist_pend_clear_group_ctrl redist_pend_chk chk (.clk, .rst_n, .ce, .reg_rd_en,
    .reg_mod_sel, .reg_nonsecure, .reg_rd_valid, .reg_addr, .reg_rdata, .security_disable_flag,
    .sysreg_access_enable, .secure_affinity_route_enable, .shared_set_pending_reg,
    .pending_out, .group_code_out);
`default_nettype wire

// ---- verification/redist_pend_clear_group_ctrl_tb.sv ----
// Purpose: directed bench of pending clear and group logic
// Assumes: inputs driven on the falling edge
// Notes:   config written before any check, it has no reset value
`default_nettype none
`include "redist_pend_map.vh"
module redist_pend_clear_group_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, ce = 1, reg_wr_en = 0, reg_rd_en = 0, reg_nonsecure = 0;
    logic reg_mod_sel = 0, alias_wr_en = 0, alias_rd_en = 0;
    logic processing_element_first_eight = 0;
    logic security_disable_flag = 1, sysreg_access_enable = 1;
    logic secure_affinity_route_enable = 1, nonsecure_affinity_route_enable = 1;
    logic [`ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, alias_wdata = '0, shared_set_pending_reg = '0;
    logic [15:0] software_raised_irq = '0, line_req = '0;
    wire [31:0] reg_rdata, alias_rdata, pending_out;
    wire [63:0] group_code_out;
    wire [15:0] per_core_private_irq;
    wire reg_rd_valid;
    int error_cnt = 0, check_count = 0;
    redist_pend_clear_group_ctrl dut (.*);
    irq_lines far (.line_req(line_req), .per_core_private_irq(per_core_private_irq));
    always #10 clk = ~clk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1;
        @(negedge clk);
        reg_wr_en = 0;
    endtask
    task automatic rdc(input logic [`ADDR_W-1:0] a, input logic [31:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1;
        @(negedge clk);
        reg_rd_en = 0;
        chk({reg_rd_valid, reg_rdata}, {1'b1, e});
    endtask
    task automatic setp(input logic [31:0] v);
        @(negedge clk);
        shared_set_pending_reg = v;
        @(negedge clk);
        shared_set_pending_reg = '0;
    endtask
    task automatic t_clear;
        setp(32'h8000_0001);
        rdc(`OFS_CLR_PEND, 32'h8000_0001);
        wr(`OFS_CLR_PEND, 32'h0000_0000);
        rdc(`OFS_CLR_PEND, 32'h8000_0001);
        wr(`OFS_CLR_PEND, 32'h8000_0000);
        rdc(`OFS_CLR_PEND, 32'h0000_0001);
        wr(`OFS_CLR_PEND, 32'h0000_0001);
        rdc(12'h100, 32'h0000_0000);
        @(negedge clk);
        software_raised_irq = 16'h0004;
        @(negedge clk);
        software_raised_irq = '0;
        rdc(`OFS_CLR_PEND, 32'h0000_0004);
        wr(`OFS_CLR_PEND, 32'h0000_0004);
        rdc(`OFS_CLR_PEND, 32'h0000_0000);
    endtask
    task automatic t_level;
        line_req = 16'h0001;
        repeat (6) @(negedge clk);
        wr(`OFS_CLR_PEND, 32'h0001_0000);
        rdc(`OFS_CLR_PEND, 32'h0001_0000);
        line_req = 16'h0000;
        repeat (6) @(negedge clk);
        chk(pending_out, 32'h0000_0000);
        wr(`OFS_CFG_HI, 32'h0000_0002);
        rdc(`OFS_CFG_HI, 32'h0000_0002);
        line_req = 16'h0001;
        repeat (6) @(negedge clk);
        line_req = 16'h0000;
        repeat (6) @(negedge clk);
        chk(pending_out, 32'h0001_0000);
        wr(`OFS_CLR_PEND, 32'h0001_0000);
        rdc(`OFS_CLR_PEND, 32'h0000_0000);
    endtask
    task automatic t_group;
        wr(`OFS_GROUP, 32'h0000_0001);
        repeat (3) @(negedge clk);
        chk(group_code_out[3:0], 4'h1);
        security_disable_flag = 0;
        reg_mod_sel = 1;
        wr(`OFS_GROUP, 32'h0000_0006);
        reg_mod_sel = 0;
        wr(`OFS_GROUP, 32'h0000_0005);
        repeat (3) @(negedge clk);
        chk(group_code_out[7:0], 8'h19);
        sysreg_access_enable = 0;
        repeat (3) @(negedge clk);
        chk(group_code_out[7:0], 8'h11);
        sysreg_access_enable = 1;
    endtask
    task automatic t_secure;
        reg_nonsecure = 1;
        rdc(`OFS_GROUP, 32'h0000_0000);
        wr(`OFS_GROUP, 32'hffff_ffff);
        reg_nonsecure = 0;
        rdc(`OFS_GROUP, 32'h0000_0005);
        setp(32'h0000_0008);
        reg_nonsecure = 1;
        wr(`OFS_CLR_PEND, 32'h0000_0008);
        reg_nonsecure = 0;
        rdc(`OFS_CLR_PEND, 32'h0000_0008);
        wr(`OFS_CLR_PEND, 32'h0000_0008);
        secure_affinity_route_enable = 0;
        reg_mod_sel = 1;
        rdc(`OFS_GROUP, 32'h0000_0000);
        reg_mod_sel = 0;
    endtask
    task automatic t_alias;
        security_disable_flag = 1;
        processing_element_first_eight = 1;
        setp(32'h0000_0010);
        rdc(`OFS_CLR_PEND, 32'h0000_0000);
        @(negedge clk);
        alias_wdata = 32'h0000_00f0;
        alias_wr_en = 1;
        @(negedge clk);
        alias_wr_en = 0;
        alias_rd_en = 1;
        @(negedge clk);
        alias_rd_en = 0;
        chk(alias_rdata, 32'h0000_00f0);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        wr(`OFS_CFG_HI, 32'h0000_0000);
        wr(`OFS_GROUP, 32'hffff_ffff);
        t_clear();
        t_level();
        t_group();
        t_secure();
        t_alias();
        end_sim();
    end
    // run needs about 110 cycles, so this only trips on a hang
    initial begin
        #50000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
